// ==== pmws_top.sv ====
/*
 Power mode sequencer with watchdog and suspend timer.
 Assumes a plain register port, pin-level wake inputs, and a core issuing STOP.
*/
`timescale 1ns/1ps
module pmws_top (
	// Clock and reset
	input  wire logic                clock,
	input  wire logic                rst,
	// Register port
	input  wire pmws_pkg::pmws_bus_s bus,
	output logic [7:0]               rdata,
	// Core and pins
	input  wire logic                cpu_stop,
	input  wire logic                supply_ok_pin,
	input  wire pmws_pkg::pmws_wake_s wake_pin,
	input  wire logic                brownout_int_en,
	input  wire logic                interval_timer_run,
	// Status outputs
	output pmws_pkg::pmws_mode_e     mode,
	output logic                     cpu_run,
	output logic                     converter_run_enable,
	output logic                     slow_rc_clock_on,
	output logic                     watchdog_irq,
	output logic                     watchdog_reset,
	output logic                     brownout_irq
);
	logic [1:0] ok_sync;
	pmws_pkg::pmws_wake_s wake_s1;
	pmws_pkg::pmws_wake_s wake_s2;
	logic       supply_ok;
	logic [7:0] wd_ctl;
	logic [2:0] susp_ctl;
	logic [8:0] div_cnt;
	logic       slow_tick;
	logic [21:0] wd_cnt;
	logic [9:0]  late_cnt;
	logic        late_run;
	logic [17:0] susp_cnt;
	logic [17:0] susp_limit;
	logic        susp_expire;
	logic [15:0] bo_cnt;
	logic        wd_int_en;
	logic        wd_rst_en;
	logic        wd_tmo;
	logic        any_wake;
	logic        set_conv;
	logic        wr_wd;
	logic        wr_su;
	logic        div_run;
	logic        sleep_wake;

	// Pin synchronisers
	always_ff @(posedge clock) begin
		ok_sync <= {ok_sync[0], supply_ok_pin};
		wake_s1 <= wake_pin;
		wake_s2 <= wake_s1;
	end
	assign supply_ok = ok_sync[1];
	assign wr_wd = bus.write && bus.addr == pmws_pkg::watchdog_control_off;
	assign wr_su = bus.write && bus.addr == pmws_pkg::suspend_control_off;
	assign wd_int_en = wd_ctl[pmws_pkg::wd_int_en_bit];
	assign wd_rst_en = wd_ctl[pmws_pkg::wd_reset_en_bit];

	assign slow_rc_clock_on = wd_int_en | wd_rst_en | interval_timer_run | susp_ctl[pmws_pkg::conv_en_bit];
	// Suspend timer keeps divider running
	assign div_run = slow_rc_clock_on | (susp_ctl[pmws_pkg::susp_sel_lo_bit +: 2] != 2'h0);

	always_ff @(posedge clock) begin
		if (rst || !div_run) begin
			div_cnt   <= '0;
			slow_tick <= 1'b0;
		end else if (div_cnt == 9'(pmws_pkg::slow_div_cycles - 1)) begin
			div_cnt   <= '0;
			slow_tick <= 1'b1;
		end else begin
			div_cnt   <= div_cnt + 9'h001;
			slow_tick <= 1'b0;
		end
	end

	always_comb begin
		unique case (wd_ctl[pmws_pkg::wd_sel_lo_bit +: 2])
			2'h0: wd_tmo = wd_cnt[12];
			2'h1: wd_tmo = wd_cnt[15];
			2'h2: wd_tmo = wd_cnt[18];
			2'h3: wd_tmo = wd_cnt[21];
		endcase
	end

	always_ff @(posedge clock) begin
		if (rst || (wr_wd && bus.wdata[pmws_pkg::wd_restart_bit])) begin
			wd_cnt   <= '0;
			late_cnt <= '0;
			late_run <= 1'b0;
		end else if (slow_tick) begin
			if (!late_run && wd_tmo) begin
				late_run <= 1'b1;
			end else if (late_run) begin
				late_cnt <= late_cnt + 10'h001;
			end
			if (!late_run) begin
				wd_cnt <= wd_cnt + 22'h000001;
			end
		end
	end

	always_ff @(posedge clock) begin
		if (rst) begin
			watchdog_reset <= 1'b0;
		end else begin
			watchdog_reset <= wd_rst_en && late_run && slow_tick
				&& late_cnt == 10'(pmws_pkg::wd_late_ticks - 1);
		end
	end

	always_ff @(posedge clock) begin
		if (rst) begin
			wd_ctl <= pmws_pkg::watchdog_control_rst;
		end else begin
			if (wr_wd) begin
				wd_ctl <= {bus.wdata[7:1], 1'b0};
			end
			if (wd_int_en && slow_tick && !late_run && wd_tmo) begin
				wd_ctl[pmws_pkg::wd_int_flg_bit] <= 1'b1;
			end
			if (watchdog_reset) begin
				wd_ctl[pmws_pkg::wd_reset_flg_bit] <= 1'b1;
			end
		end
	end
	assign watchdog_irq = wd_ctl[pmws_pkg::wd_int_flg_bit];

	always_comb begin
		unique case (susp_ctl[pmws_pkg::susp_sel_lo_bit +: 2])
			2'h0: susp_limit = '0;
			2'h1: susp_limit = pmws_pkg::susp_ticks_0;
			2'h2: susp_limit = pmws_pkg::susp_ticks_1;
			2'h3: susp_limit = pmws_pkg::susp_ticks_2;
		endcase
	end

	// Suspend counter, ticks while sleeping
	always_ff @(posedge clock) begin
		if (rst || mode != pmws_pkg::pmws_sleep || susp_limit == '0) begin
			susp_cnt    <= '0;
			susp_expire <= 1'b0;
		end else if (slow_tick && susp_cnt + 18'h00001 >= susp_limit) begin
			susp_cnt    <= '0;
			susp_expire <= 1'b1;
		end else begin
			if (slow_tick) begin
				susp_cnt <= susp_cnt + 18'h00001;
			end
			susp_expire <= 1'b0;
		end
	end

	always_ff @(posedge clock) begin
		if (rst) begin
			susp_ctl <= pmws_pkg::suspend_control_rst[2:0];
		end else begin
			if (wr_su) begin
				susp_ctl <= bus.wdata[2:0];
			end
			if (set_conv) begin
				susp_ctl[pmws_pkg::conv_en_bit] <= 1'b1;
			end
		end
	end
	assign converter_run_enable = susp_ctl[pmws_pkg::conv_en_bit];

	assign any_wake = wake_s2.ext_irq | wake_s2.int_irq | wake_s2.ext_reset | watchdog_irq;
	assign sleep_wake = wake_s2.serial_irq | wake_s2.port_irq | wake_s2.ext_reset;
	assign set_conv = mode == pmws_pkg::pmws_sleep && susp_expire && !sleep_wake;

	always_ff @(posedge clock) begin
		if (rst) begin
			mode         <= pmws_pkg::pmws_brownout;
			bo_cnt       <= '0;
			brownout_irq <= 1'b0;
		end else begin
			unique case (mode)
				pmws_pkg::pmws_brownout: begin
					if (supply_ok) begin
						mode   <= pmws_pkg::pmws_cpu;
						bo_cnt <= '0;
						brownout_irq <= brownout_int_en;
					end else if (bo_cnt == 16'(pmws_pkg::restart_delay_cycles - 1)) begin
						mode   <= pmws_pkg::pmws_sleep;
						bo_cnt <= '0;
					end else begin
						bo_cnt <= bo_cnt + 16'h0001;
					end
				end
				pmws_pkg::pmws_cpu: begin
					brownout_irq <= 1'b0;
					if (!supply_ok) begin
						mode <= pmws_pkg::pmws_brownout;
					end else if (cpu_stop) begin
						if (converter_run_enable || interval_timer_run || wd_int_en || wd_rst_en) begin
							mode <= pmws_pkg::pmws_analog;
						end else begin
							mode <= pmws_pkg::pmws_sleep;
						end
					end
				end
				pmws_pkg::pmws_analog: begin
					if (!supply_ok) begin
						mode <= pmws_pkg::pmws_brownout;
					end else if (any_wake) begin
						mode <= pmws_pkg::pmws_cpu;
					end else if (!converter_run_enable && !interval_timer_run && !wd_int_en && !wd_rst_en) begin
						// idle analog falls back to sleep
						mode <= pmws_pkg::pmws_sleep;
					end
				end
				pmws_pkg::pmws_sleep: begin
					// serial, port or external reset wake via brownout
					if (sleep_wake) begin
						mode <= pmws_pkg::pmws_brownout;
					end else if (susp_expire) begin
						mode <= pmws_pkg::pmws_analog;
					end
				end
			endcase
		end
	end
	assign cpu_run = mode == pmws_pkg::pmws_cpu;

	always_ff @(posedge clock) begin
		if (rst) begin
			rdata <= '0;
		end else if (bus.read) begin
			unique case (bus.addr)
				pmws_pkg::watchdog_control_off: rdata <= wd_ctl;
				pmws_pkg::suspend_control_off:  rdata <= {5'h00, susp_ctl};
				pmws_pkg::clock_control_off:    rdata <= pmws_pkg::clock_control_rst;
				default:                        rdata <= 8'h00;
			endcase
		end else begin
			rdata <= 8'h00;
		end
	end

	a_reset_mode: assert property (@(posedge clock) rst |=> mode == pmws_pkg::pmws_brownout)
		else $error("mode not brownout after reset");
	a_por_flag: assert property (@(posedge clock) rst |=> wd_ctl[pmws_pkg::wd_por_bit])
		else $error("power-on flag not set after reset");
	a_supply_loss: assert property (@(posedge clock) disable iff (rst)
		((mode == pmws_pkg::pmws_cpu || mode == pmws_pkg::pmws_analog) && !supply_ok)
		|=> mode == pmws_pkg::pmws_brownout)
		else $error("no brownout on supply loss");
	a_sleep_quiet: assert property (@(posedge clock) disable iff (rst)
		(mode == pmws_pkg::pmws_sleep && !sleep_wake && !susp_expire) |=> mode == pmws_pkg::pmws_sleep)
		else $error("sleep left without wake");
	a_sleep_wake: assert property (@(posedge clock) disable iff (rst)
		(mode == pmws_pkg::pmws_sleep && wake_s2.serial_irq) |=> mode == pmws_pkg::pmws_brownout)
		else $error("sleep did not wake to brownout");
	sequence s_sleep_expire;
		mode == pmws_pkg::pmws_sleep && susp_expire && !sleep_wake;
	endsequence
	sequence s_analog_conv;
		mode == pmws_pkg::pmws_analog && converter_run_enable;
	endsequence
	a_susp_analog: assert property (@(posedge clock) disable iff (rst)
		s_sleep_expire |=> s_analog_conv)
		else $error("suspend expiry did not enter analog");
	a_conv_set: assert property (@(posedge clock) disable iff (rst)
		set_conv |=> converter_run_enable && mode == pmws_pkg::pmws_analog)
		else $error("converter not enabled on suspend wake");
	a_stop_sleep: assert property (@(posedge clock) disable iff (rst)
		(cpu_run && supply_ok && cpu_stop && !slow_rc_clock_on) |=> mode == pmws_pkg::pmws_sleep)
		else $error("stop did not sleep");
	a_stop_analog: assert property (@(posedge clock) disable iff (rst)
		(cpu_run && supply_ok && cpu_stop && converter_run_enable) |=> mode == pmws_pkg::pmws_analog)
		else $error("stop did not enter analog");
	a_wdi_wake: assert property (@(posedge clock) disable iff (rst)
		(mode == pmws_pkg::pmws_analog && supply_ok && watchdog_irq) |=> cpu_run)
		else $error("watchdog interrupt did not wake");
	a_analog_wake: assert property (@(posedge clock) disable iff (rst)
		(mode == pmws_pkg::pmws_analog && supply_ok && (wake_s2.ext_irq || wake_s2.int_irq)) |=> cpu_run)
		else $error("analog interrupt did not wake");
	a_bo_sleep: assert property (@(posedge clock) disable iff (rst)
		(mode == pmws_pkg::pmws_brownout && !supply_ok && bo_cnt == 16'(pmws_pkg::restart_delay_cycles - 1))
		|=> mode == pmws_pkg::pmws_sleep)
		else $error("brownout did not time out to sleep");
	a_restart: assert property (@(posedge clock) disable iff (rst)
		(wr_wd && bus.wdata[0]) |=> wd_cnt == '0 && !late_run)
		else $error("watchdog not restarted");
	a_late_reset: assert property (@(posedge clock) disable iff (rst)
		watchdog_reset |-> $past(late_run) && $past(wd_rst_en))
		else $error("watchdog reset outside late phase");
	a_bo_irq: assert property (@(posedge clock) disable iff (rst)
		(mode == pmws_pkg::pmws_brownout && supply_ok && brownout_int_en) |=> brownout_irq && cpu_run)
		else $error("no brownout interrupt on recovery");
endmodule

// ==== pmws_pkg.sv ====
/*
 Package for the power mode, watchdog and suspend timer block.
 Assumes a 20 MHz single clock; slow RC rate derived by an enable divider.
*/
package pmws_pkg;
	// Register offsets
	localparam logic [7:0] clock_control_off   = 8'h0e;
	localparam logic [7:0] watchdog_control_off = 8'h0f;
	localparam logic [7:0] suspend_control_off  = 8'h05;
	// Watchdog control fields
	localparam int wd_restart_bit   = 0;
	localparam int wd_reset_en_bit  = 1;
	localparam int wd_reset_flg_bit = 2;
	localparam int wd_int_flg_bit   = 3;
	localparam int wd_sel_lo_bit    = 4;
	localparam int wd_int_en_bit    = 6;
	localparam int wd_por_bit       = 7;
	// Suspend control fields
	localparam int conv_en_bit      = 0;
	localparam int susp_sel_lo_bit  = 1;
	// Reset values
	localparam logic [7:0] watchdog_control_rst = 8'h80;
	localparam logic [7:0] suspend_control_rst  = 8'h00;
	localparam logic [7:0] clock_control_rst    = 8'h00;
	// Timing
	localparam int clk_hz          = 20000000;
	localparam int slow_hz         = 70000;
	localparam int slow_div_cycles = clk_hz / slow_hz;
	localparam int wd_late_ticks   = 512;
	localparam int restart_delay_us = 1000;
	localparam int restart_delay_cycles = restart_delay_us * (clk_hz / 1000000);
	// Suspend timeouts in ms, converted to slow ticks
	localparam int susp_ms_0 = 500;
	localparam int susp_ms_1 = 1000;
	localparam int susp_ms_2 = 2000;
	localparam logic [17:0] susp_ticks_0 = 18'(susp_ms_0 * slow_hz / 1000);
	localparam logic [17:0] susp_ticks_1 = 18'(susp_ms_1 * slow_hz / 1000);
	localparam logic [17:0] susp_ticks_2 = 18'(susp_ms_2 * slow_hz / 1000);

	typedef enum logic [1:0] {pmws_brownout, pmws_cpu, pmws_analog, pmws_sleep} pmws_mode_e;

	typedef struct packed {
		logic       write;
		logic       read;
		logic [7:0] addr;
		logic [7:0] wdata;
	} pmws_bus_s;

	typedef struct packed {
		logic ext_irq;
		logic serial_irq;
		logic port_irq;
		logic int_irq;
		logic ext_reset;
	} pmws_wake_s;
endpackage

// ==== testbench.sv ====
/*
 Self-checking testbench for the power mode, watchdog and suspend block.
 Assumes pmws_pkg and pmws_top compiled first; design carries its own assertions.
*/
`timescale 1ns/1ps
module testbench;
	logic                    clock = 1'b0;
	logic                    rst = 1'b1;
	pmws_pkg::pmws_bus_s     bus = '0;
	logic [7:0]              rdata;
	logic                    cpu_stop = 1'b0;
	logic                    supply_ok_pin = 1'b1;
	pmws_pkg::pmws_wake_s    wake_pin = '0;
	logic                    brownout_int_en = 1'b0;
	logic                    interval_timer_run = 1'b0;
	pmws_pkg::pmws_mode_e    mode;
	logic                    cpu_run;
	logic                    converter_run_enable;
	logic                    slow_rc_clock_on;
	logic                    watchdog_irq;
	logic                    watchdog_reset;
	logic                    brownout_irq;
	int                      n_mismatch = 0;
	int                      num_checks = 0;
	int                      n_boi = 0;
	pmws_pkg::pmws_wake_s    wk [3];

	pmws_top i_dut (.clock(clock), .rst(rst), .bus(bus), .rdata(rdata), .cpu_stop(cpu_stop),
		.supply_ok_pin(supply_ok_pin), .wake_pin(wake_pin), .brownout_int_en(brownout_int_en),
		.interval_timer_run(interval_timer_run), .mode(mode), .cpu_run(cpu_run),
		.converter_run_enable(converter_run_enable), .slow_rc_clock_on(slow_rc_clock_on),
		.watchdog_irq(watchdog_irq), .watchdog_reset(watchdog_reset), .brownout_irq(brownout_irq));

	always #25 clock = ~clock;

	always @(posedge clock) begin
		if (brownout_irq === 1'b1)
			n_boi++;
	end

	task check(input string name, input logic [7:0] seen, input logic [7:0] exp);
		num_checks++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("wrong value %s expected %h seen %h", name, exp, seen);
		end
	endtask

	task wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clock) bus <= '{1'b1, 1'b0, a, d};
		@(posedge clock) bus <= '0;
	endtask

	task rd(input logic [7:0] a, input logic [7:0] exp, input string name);
		@(posedge clock) bus <= '{1'b0, 1'b1, a, 8'h00};
		@(posedge clock) bus <= '0;
		#1;
		check(name, rdata, exp);
	endtask

	task wait_mode(input pmws_pkg::pmws_mode_e e, input int lim, input string name);
		for (int i = 0; i < lim; i++) begin
			@(posedge clock);
			#1;
			if (mode === e)
				break;
		end
		check(name, 8'(mode), 8'(e));
	endtask

	task stop_pulse();
		@(posedge clock) cpu_stop <= 1'b1;
		@(posedge clock) cpu_stop <= 1'b0;
	endtask

	task final_report();
		$display("checks %0d mismatches %0d", num_checks, n_mismatch);
		if (n_mismatch == 0 && num_checks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask

	initial begin
		#2_000_000;
		n_mismatch++;
		final_report();
	end

	initial begin
		wk[0] = '{1'b1, 1'b0, 1'b0, 1'b0, 1'b0};
		wk[1] = '{1'b0, 1'b1, 1'b0, 1'b0, 1'b0};
		wk[2] = '{1'b0, 1'b0, 1'b0, 1'b1, 1'b0};
		repeat (6) @(posedge clock);
		check("mode_in_reset", 8'(mode), 8'(pmws_pkg::pmws_brownout));
		rst <= 1'b0;
		wait_mode(pmws_pkg::pmws_cpu, 50, "mode_after_por");
		rd(pmws_pkg::watchdog_control_off, 8'h80, "wd_reset");
		rd(pmws_pkg::suspend_control_off, 8'h00, "susp_reset");
		wr(pmws_pkg::clock_control_off, 8'hff);
		rd(pmws_pkg::clock_control_off, 8'h00, "clock_reg");
		wr(8'h33, 8'hff);
		rd(8'h33, 8'h00, "unmapped");
		wr(pmws_pkg::suspend_control_off, 8'h07);
		rd(pmws_pkg::suspend_control_off, 8'h07, "susp_rw");
		check("conv_en", 8'(converter_run_enable), 8'h01);
		check("slow_on_conv", 8'(slow_rc_clock_on), 8'h01);
		wr(pmws_pkg::suspend_control_off, 8'h00);
		wr(pmws_pkg::watchdog_control_off, 8'h81);
		rd(pmws_pkg::watchdog_control_off, 8'h80, "wd_restart");
		wr(pmws_pkg::watchdog_control_off, 8'h40);
		rd(pmws_pkg::watchdog_control_off, 8'h40, "wd_int_en");
		check("slow_on_wd", 8'(slow_rc_clock_on), 8'h01);
		wr(pmws_pkg::watchdog_control_off, 8'h00);
		#1;
		check("slow_off", 8'(slow_rc_clock_on), 8'h00);
		$display("test registers done");

		stop_pulse();
		wait_mode(pmws_pkg::pmws_sleep, 50, "stop_to_sleep");
		supply_ok_pin <= 1'b0;
		repeat (100) @(posedge clock);
		check("sleep_no_bo", 8'(mode), 8'(pmws_pkg::pmws_sleep));
		supply_ok_pin <= 1'b1;
		repeat (5) @(posedge clock);
		wake_pin.port_irq <= 1'b1;
		wait_mode(pmws_pkg::pmws_brownout, 50, "sleep_to_bo");
		wait_mode(pmws_pkg::pmws_cpu, 50, "bo_to_cpu");
		wake_pin.port_irq <= 1'b0;
		$display("test sleep done");

		for (int i = 0; i < 3; i++) begin
			if (i == 0)
				interval_timer_run <= 1'b1;
			else if (i == 1)
				wr(pmws_pkg::suspend_control_off, 8'h01);
			else
				wr(pmws_pkg::watchdog_control_off, 8'h40);
			stop_pulse();
			wait_mode(pmws_pkg::pmws_analog, 50, "stop_to_analog");
			if (i == 1) begin
				wr(pmws_pkg::suspend_control_off, 8'h00);
				wait_mode(pmws_pkg::pmws_sleep, 50, "analog_to_sleep");
				wake_pin <= wk[i];
				wait_mode(pmws_pkg::pmws_cpu, 100, "serial_wake");
				wake_pin <= '0;
			end else begin
				wake_pin <= wk[i];
				wait_mode(pmws_pkg::pmws_cpu, 50, "analog_wake");
				wake_pin <= '0;
			end
			interval_timer_run <= 1'b0;
			wr(pmws_pkg::watchdog_control_off, 8'h00);
		end
		$display("test analog done");

		brownout_int_en <= 1'b1;
		n_boi = 0;
		supply_ok_pin <= 1'b0;
		wait_mode(pmws_pkg::pmws_brownout, 50, "cpu_to_bo");
		check("halted", 8'(cpu_run), 8'h00);
		repeat (100) @(posedge clock);
		supply_ok_pin <= 1'b1;
		wait_mode(pmws_pkg::pmws_cpu, 50, "bo_recover");
		repeat (3) @(posedge clock);
		check("bo_irq", 8'(n_boi), 8'h01);
		supply_ok_pin <= 1'b0;
		wait_mode(pmws_pkg::pmws_brownout, 50, "cpu_to_bo2");
		wait_mode(pmws_pkg::pmws_sleep, 21000, "long_bo");
		supply_ok_pin <= 1'b1;
		wake_pin.ext_reset <= 1'b1;
		wait_mode(pmws_pkg::pmws_cpu, 100, "wake_after_bo");
		wake_pin.ext_reset <= 1'b0;
		$display("test brownout done");

		rst <= 1'b1;
		repeat (2) @(posedge clock);
		check("mode_mid_reset", 8'(mode), 8'(pmws_pkg::pmws_brownout));
		rst <= 1'b0;
		wait_mode(pmws_pkg::pmws_cpu, 50, "cpu_after_reset");
		rd(pmws_pkg::watchdog_control_off, 8'h80, "por_after_reset");
		$display("test reset done");
		final_report();
	end
endmodule
